// *** design/atm_defs.svh ***
// register offsets, field positions and reset values of the alert monitor
// assumes inclusion by the monitor module only
`ifndef ATM_DEFS_SVH
`define ATM_DEFS_SVH

// ==========================================================
// register addresses (four-bit address field)
`define ATM_ADDR_FLAGS     4'h1
`define ATM_ADDR_LOW       4'h2
`define ATM_ADDR_HIGH      4'h3
`define ATM_ADDR_IRQ_STAT  4'h4
`define ATM_ADDR_IRQ_MASK  4'h5

// ==========================================================
// field positions
`define ATM_ADDR_MSB       15
`define ATM_ADDR_LSB       12
`define ATM_THR_MSB        11

// ==========================================================
// reset values and fixed fill bits
`define ATM_LOW_RESET      12'h800
`define ATM_HIGH_RESET     12'h7ff
`define ATM_LOW_FILL       4'h0
`define ATM_HIGH_FILL      4'hf

`endif

// *** design/atm_pkg.sv ***
// types shared by the alert monitor
// assumes atm_defs.svh in the include path
package atm_pkg;
    // ==========================================================
    // types
    typedef logic [15:0] atm_word_type;  // one register word / result
    typedef logic [11:0] atm_thr_type;   // threshold field
    typedef logic [7:0]  atm_flag_type;  // two flags per channel
endpackage : atm_pkg

// *** design/atm_monitor.sv ***
// quad-channel threshold alert monitor with register port and interrupt
// assumes results come from logic on clk_sys_i, one valid pulse per set
`timescale 1ns/100ps
`include "atm_defs.svh"

// ==========================================================
// register map, as software sees it
// every word carries its register address in bits 15:12
// writes are decoded on that embedded field, not on the read address
// reads use the separate four-bit read address and echo it back on top
//
//   0x1  crossing flags, read clears, writes ignored
//        bit 2n     channel n result under the low limit
//        bit 2n+1   channel n result over the high limit
//        channel A is n = 0, channel D is n = 3
//        bits 11:8 always read zero
//   0x2  low limit field, bits 11:0, read/write
//   0x3  high limit field, bits 11:0, read/write
//   0x4  interrupt status, write one to clear
//        bit 0 any low crossing, bit 1 any high crossing
//   0x5  interrupt mask, same layout as status
//   any other address reads zero and ignores writes
//
// limits are shared by all four channels; a result is compared
// against the field widened to 16 bits, low padded with zeros,
// high padded with ones, so a limit field covers a full 16-step band
//
// compares are strict: a result equal to a widened limit raises
// nothing, which keeps the reset limits (0x8000 and 0x7fff) from
// flagging a mid-scale result on both sides at once
//
// hazard: a crossing landing in the very cycle of a flag read is kept,
// so software never loses an event between the read and the clear;
// the price is that such a flag shows up again on the next read
//
// limitation: the flag read returns the flags as they stood before
// the read cycle; a crossing in the read cycle itself is only
// visible on the following read or on the mirror output
//
// the interrupt line is registered once more after status, so it
// trails a crossing by two cycles; software must not expect it sooner

module atm_monitor
    import atm_pkg::*;
(
    input  wire logic         clk_sys_i,      // system clock, 125 MHz
    input  wire logic         resetn_i,       // synchronous reset, active low
    input  wire logic [15:0]  reg_wdata_i,    // write word, address in top bits
    input  wire logic [3:0]   reg_addr_i,     // read address
    input  wire logic         reg_wr_i,       // write strobe
    input  wire logic         reg_rd_i,       // read strobe
    input  wire logic [63:0]  res_data_i,     // four 16-bit results, ch A low
    input  wire logic         res_valid_i,    // one-cycle completed conversion
    output logic      [15:0]  reg_rdata_o,    // read data, cycle after strobe
    output logic      [7:0]   alert_flags_o,  // current sticky flags
    output logic              irq_o           // level interrupt
);

    // ==========================================================
    // state
    atm_thr_type  low_thr_q;      // low threshold field
    atm_thr_type  high_thr_q;     // high threshold field
    atm_flag_type flags_q;        // sticky crossing flags
    atm_flag_type hit_d;          // crossings of this result set
    atm_word_type low_eff;        // widened low threshold
    atm_word_type high_eff;       // widened high threshold
    logic [1:0]   irq_stat_q;     // bit0 any low crossing, bit1 any high
    logic [1:0]   irq_mask_q;     // interrupt enables
    logic [3:0]   wr_addr;        // address taken from the write word
    logic         flag_rd;        // read of the flag register

    assign wr_addr = reg_wdata_i[`ATM_ADDR_MSB:`ATM_ADDR_LSB];
    assign flag_rd = reg_rd_i && (reg_addr_i == `ATM_ADDR_FLAGS);

    // ==========================================================
    // effective thresholds
    // the fill nibbles are constants, so the widened limits cost no
    // flip-flops; only the 12-bit fields are stored
    assign low_eff  = {low_thr_q, `ATM_LOW_FILL};
    assign high_eff = {high_thr_q, `ATM_HIGH_FILL};

    // ==========================================================
    // per-channel comparators, same limits for all four
    // results are unsigned 16-bit words; the hit vector is only
    // nonzero in the cycle of a valid pulse, so idle inputs with
    // stale data can never raise a flag
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            // strict compares: equal to a limit raises nothing
            assign hit_d[2*ch]   = res_valid_i &&
                                   (res_data_i[16*ch +: 16] < low_eff);
            assign hit_d[2*ch+1] = res_valid_i &&
                                   (res_data_i[16*ch +: 16] > high_eff);
        end
    endgenerate

    // ==========================================================
    // threshold registers
    // a write whose embedded address matches neither limit leaves
    // both fields alone, including writes aimed at the flag register
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            low_thr_q  <= `ATM_LOW_RESET;
            high_thr_q <= `ATM_HIGH_RESET;
        end else if (reg_wr_i) begin
            // write decoded on the embedded address field
            if (wr_addr == `ATM_ADDR_LOW) begin
                low_thr_q <= reg_wdata_i[`ATM_THR_MSB:0];
            end
            if (wr_addr == `ATM_ADDR_HIGH) begin
                high_thr_q <= reg_wdata_i[`ATM_THR_MSB:0];
            end
        end
    end

    // ==========================================================
    // sticky flags: a new crossing wins over the read clear
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            flags_q <= 8'h00;
        end else if (flag_rd) begin
            flags_q <= hit_d;
        end else begin
            flags_q <= flags_q | hit_d;
        end
    end

    // ==========================================================
    // interrupt status, write one to clear, set wins
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q[0] <= (irq_stat_q[0] &
                ~(reg_wr_i && wr_addr == `ATM_ADDR_IRQ_STAT && reg_wdata_i[0]))
                | (|{hit_d[6], hit_d[4], hit_d[2], hit_d[0]});
            irq_stat_q[1] <= (irq_stat_q[1] &
                ~(reg_wr_i && wr_addr == `ATM_ADDR_IRQ_STAT && reg_wdata_i[1]))
                | (|{hit_d[7], hit_d[5], hit_d[3], hit_d[1]});
        end
    end

    // interrupt mask register
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            irq_mask_q <= 2'h0;
        end else if (reg_wr_i && wr_addr == `ATM_ADDR_IRQ_MASK) begin
            irq_mask_q <= reg_wdata_i[1:0];
        end
    end

    // registered interrupt line, one cycle behind status
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // flags mirrored out registered
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            alert_flags_o <= 8'h00;
        end else begin
            alert_flags_o <= flag_rd ? hit_d : (flags_q | hit_d);
        end
    end

    // ==========================================================
    // read data: address echoed in the top bits, zero otherwise
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `ATM_ADDR_FLAGS:    reg_rdata_o <= {reg_addr_i, 4'h0, flags_q};
                `ATM_ADDR_LOW:      reg_rdata_o <= {reg_addr_i, low_thr_q};
                `ATM_ADDR_HIGH:     reg_rdata_o <= {reg_addr_i, high_thr_q};
                `ATM_ADDR_IRQ_STAT: reg_rdata_o <= {reg_addr_i, 10'h000, irq_stat_q};
                `ATM_ADDR_IRQ_MASK: reg_rdata_o <= {reg_addr_i, 10'h000, irq_mask_q};
                default:            reg_rdata_o <= 16'h0000;  // unmapped reads zero
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    // ==========================================================
    // checks
    AST_HIGH_SET: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        hit_d[1] |=> flags_q[1])
        else $error("channel A high crossing not recorded");
    AST_LOW_SET: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        hit_d[0] |=> flags_q[0])
        else $error("channel A low crossing not recorded");
    AST_STICKY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (!flag_rd && flags_q != 8'h00) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("flag dropped without a read");
    AST_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (flag_rd && !res_valid_i) |=> flags_q == 8'h00)
        else $error("flags not cleared by read");
    AST_LOW_CMP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[15:0] >= {low_thr_q, 4'h0}) |-> !hit_d[0])
        else $error("low alert without crossing");
    AST_HIGH_CMP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[15:0] <= {high_thr_q, 4'hf}) |-> !hit_d[1])
        else $error("high alert without crossing");
    AST_RD_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        flag_rd |=> reg_rdata_o[7:0] == $past(flags_q))
        else $error("flag read data wrong");
    AST_THR_WR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_wdata_i[15:12] == 4'h3) |=> high_thr_q == $past(reg_wdata_i[11:0]))
        else $error("high threshold write lost");
    AST_CHD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[63:48] > {high_thr_q, 4'hf}) |=> flags_q[7])
        else $error("channel D high not recorded");
    AST_RESET: assert property (@(posedge clk_sys_i)
        !resetn_i |=> (low_thr_q == 12'h800 && high_thr_q == 12'h7ff))
        else $error("threshold reset values wrong");

    // ==========================================================
    // checks on the remaining channels, same limits as channel A
    AST_CHB_LOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[31:16] < {low_thr_q, 4'h0}) |=> flags_q[2])
        else $error("channel B low not recorded");
    AST_CHB_HIGH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[31:16] > {high_thr_q, 4'hf}) |=> flags_q[3])
        else $error("channel B high not recorded");
    AST_CHC_LOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[47:32] < {low_thr_q, 4'h0}) |=> flags_q[4])
        else $error("channel C low not recorded");
    AST_CHC_HIGH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[47:32] > {high_thr_q, 4'hf}) |=> flags_q[5])
        else $error("channel C high not recorded");
    AST_CHD_LOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (res_valid_i && res_data_i[63:48] < {low_thr_q, 4'h0}) |=> flags_q[6])
        else $error("channel D low not recorded");

    // no result pulse, no crossing, whatever the data lines show
    AST_NO_VALID: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !res_valid_i |-> hit_d == 8'h00)
        else $error("crossing without a result");

    // fill nibbles of the widened limits
    AST_LOW_FILL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        low_eff[3:0] == 4'h0)
        else $error("low limit fill wrong");
    AST_HIGH_FILL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        high_eff[3:0] == 4'hf)
        else $error("high limit fill wrong");

    // ==========================================================
    // checks on the register port
    AST_LOW_WR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_wdata_i[15:12] == 4'h2) |=> low_thr_q == $past(reg_wdata_i[11:0]))
        else $error("low threshold write lost");
    AST_WR_OTHER: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_wdata_i[15:12] != 4'h2 && reg_wdata_i[15:12] != 4'h3)
        |=> ($stable(low_thr_q) && $stable(high_thr_q)))
        else $error("limit changed by a foreign write");
    AST_NO_WR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !reg_wr_i |=> ($stable(low_thr_q) && $stable(high_thr_q)))
        else $error("limit changed without a write");
    AST_RD_ADDR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i >= 4'h1 && reg_addr_i <= 4'h5)
        |=> reg_rdata_o[15:12] == $past(reg_addr_i))
        else $error("read address not echoed");
    AST_RD_UNMAPPED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_rd_i && (reg_addr_i == 4'h0 || reg_addr_i > 4'h5)) |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    // read data stand for one cycle only, then the port goes quiet
    AST_RD_IDLE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside the answer cycle");

    // ==========================================================
    // checks on the mirror output and the interrupt path
    AST_FLAGS_OUT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        alert_flags_o == flags_q)
        else $error("flag mirror differs from flags");
    AST_STAT_HIGH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (|{hit_d[7], hit_d[5], hit_d[3], hit_d[1]}) |=> irq_stat_q[1])
        else $error("high crossing not in status");
    AST_STAT_LOW: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (|{hit_d[6], hit_d[4], hit_d[2], hit_d[0]}) |=> irq_stat_q[0])
        else $error("low crossing not in status");
    AST_MASK_WR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (reg_wr_i && reg_wdata_i[15:12] == 4'h5) |=> irq_mask_q == $past(reg_wdata_i[1:0]))
        else $error("mask write lost");
    // interrupt line trails masked status by exactly one cycle
    AST_IRQ_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        irq_o == |($past(irq_stat_q) & $past(irq_mask_q)))
        else $error("interrupt line wrong");

endmodule : atm_monitor

// *** tb/atm_host.sv ***
// host-side model: register strobes and conversion results for the monitor
// assumes one clock, requests launched right after a rising edge
`timescale 1ns/100ps
module atm_host (
    input  wire logic        clk_i,        // system clock
    output logic      [15:0] wdata_o,      // write word, address on top
    output logic      [3:0]  addr_o,       // read address
    output logic             wr_o,         // write strobe
    output logic             rd_o,         // read strobe
    output logic      [63:0] res_data_o,   // four results, ch A low
    output logic             res_valid_o   // result pulse
);
    // ==========================================================
    // idle values from time zero
    initial begin
        {wdata_o, addr_o, wr_o, rd_o, res_data_o, res_valid_o} = '0;
    end
    // one-cycle write; address rides in bits 15:12
    task automatic wr(input logic [15:0] w);
        @(posedge clk_i);
        wr_o    <= 1'b1;
        wdata_o <= w;
        @(posedge clk_i);
        wr_o    <= 1'b0;
        wdata_o <= ~w; // no stale word after release
    endtask : wr
    // one-cycle read strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
    endtask : rd
    // one completed set of four results
    task automatic res(input logic [63:0] r);
        @(posedge clk_i);
        res_valid_o <= 1'b1;
        res_data_o  <= r;
        @(posedge clk_i);
        res_valid_o <= 1'b0;
        res_data_o  <= ~r;
    endtask : res
endmodule : atm_host

// *** tb/atm_monitor_tb_top.sv ***
// self-checking bench of the alert monitor; read results checked from a queue
// assumes atm_host as register and result source
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", nm, e, a); end end
module atm_monitor_tb_top import atm_pkg::*;;
    logic         clk_sys = 1'b0, resetn = 1'b0, rd_seen = 1'b0;
    logic  [15:0] wd, rdat;
    logic  [3:0]  ra;
    logic         wr, rd, rv, irq;
    logic  [63:0] rs, r;
    atm_flag_type flags;
    atm_word_type e;
    atm_word_type exp_q[$];  // expected read words, oldest first
    logic  [11:0] lo_t = 12'h800, hi_t = 12'h7ff;
    int           n_fail = 0, n_tests = 0, seed = 4973;
    atm_host host (.clk_i(clk_sys), .wdata_o(wd), .addr_o(ra), .wr_o(wr), .rd_o(rd),
                   .res_data_o(rs), .res_valid_o(rv));
    atm_monitor uut (.clk_sys_i(clk_sys), .resetn_i(resetn), .reg_wdata_i(wd),
                     .reg_addr_i(ra), .reg_wr_i(wr), .reg_rd_i(rd), .res_data_i(rs),
                     .res_valid_i(rv), .reg_rdata_o(rdat), .alert_flags_o(flags), .irq_o(irq));
    initial forever #4 clk_sys = ~clk_sys;
    // strict compares against shared padded limits
    function automatic atm_flag_type exp_flags(input logic [63:0] v);
        atm_flag_type f;
        for (int n = 0; n < 4; n++) begin
            f[2*n]   = v[16*n +: 16] < {lo_t, 4'h0};
            f[2*n+1] = v[16*n +: 16] > {hi_t, 4'hf};
        end
        return f;
    endfunction : exp_flags
    task automatic rdchk(input logic [3:0] a, input atm_word_type x);
        exp_q.push_back(x);
        host.rd(a);
    endtask : rdchk
    task automatic conclude;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // read data stand only in the cycle after the strobe
    always @(negedge clk_sys) begin
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("rdata", e, rdat)
        end
        rd_seen <= rd;
    end
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        rdchk(4'h2, 16'h2800);
        rdchk(4'h3, 16'h37ff);
        rdchk(4'h1, 16'h1000);
        rdchk(4'h7, 16'h0000);
        $display("reset values done");
        host.wr(16'h2100);
        host.wr(16'h3e00);
        lo_t = 12'h100;
        hi_t = 12'he00;
        rdchk(4'h2, 16'h2100);
        rdchk(4'h3, 16'h3e00);
        host.res(64'he010_e00f_1000_0fff);
        host.res(64'h8000_8000_8000_8000);
        rdchk(4'h1, 16'h1081);
        rdchk(4'h1, 16'h1000);
        $display("limits and sticky done");
        host.wr(16'h5002);
        host.res(64'h8000_8000_8000_ffff);
        @(posedge clk_sys);
        #1 `CHK("irq", 1'b1, irq)
        `CHK("flags", 8'h02, flags)
        host.wr(16'h4003);
        rdchk(4'h1, 16'h1002);
        #1 `CHK("irq", 1'b0, irq)
        $display("interrupt done");
        for (int i = 0; i < 8; i++) begin
            r = {$random(seed), $random(seed)};
            host.res(r);
            rdchk(4'h1, {8'h10, exp_flags(r)});
        end
        $display("random results done");
        r = {$random(seed), $random(seed)};
        lo_t = r[11:0];
        hi_t = r[43:32];
        host.wr({4'h2, lo_t});
        host.wr({4'h3, hi_t});
        for (int i = 0; i < 4; i++) begin
            r = {$random(seed), $random(seed)};
            host.res(r);
            rdchk(4'h1, {8'h10, exp_flags(r)});
        end
        $display("random limits done");
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        lo_t = 12'h800;
        hi_t = 12'h7ff;
        rdchk(4'h2, 16'h2800);
        rdchk(4'h3, 16'h37ff);
        $display("reset in run done");
        repeat (2) @(posedge clk_sys);
        conclude();
    end
endmodule : atm_monitor_tb_top
